// ===== rtl/wss_pacer.sv
`timescale 1ns/1ps
module wss_pacer
  import wss_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [23:0] div,
  output logic             tick
);
  typedef struct packed {
    logic [23:0] cnt;
  } wss_pc_s;

  wss_pc_s     r;
  wss_pc_s     next_r;
  logic [23:0] per;

  // period never below the rate cap; fast sweeps lose density
  always_comb begin
    per    = (div < 24'(MIN_SAMPLE_CYC)) ? 24'(MIN_SAMPLE_CYC) : div;
    tick   = (r.cnt >= per - 24'h1);
    next_r = r;
    if (tick) begin
      next_r.cnt = '0;
    end else begin
      next_r.cnt = r.cnt + 24'h1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule

// ===== rtl/wss_pkg.sv
// Overview of operation
// - live mode free-runs without trigger unless disabled
// - three display modes with an operating-mode indicator
// - live beyond slowest live sweep runs refreshed
// - refreshed holds last capture while untriggered
// - each refreshed trigger between sweeps rewrites the store unless stored
// - sample rate capped, density falls at fast sweeps
// - roll writes continuously, newest data at right
// - store and release ignored in live mode
// - refreshed store keeps current or next sweep
// - accepted store command lights armed lamp
// - sweep start swaps armed for triggered lamp
// - sweep end swaps triggered for stored lamp
// - new samples simply overwrite store locations
// - store while stored restarts the capture
// - release returns to triggered refresh operation
// - roll end-point store freezes on trigger
// - three-quarter point writes quarter sweep more
// - half point writes half sweep more
// - end-point roll capture skips triggered state
// - roll resume accepts trigger after full rollout
// - store is 1024 bytes, address wraps
package wss_pkg;
  // timing
  localparam int unsigned CLK_PERIOD_NS   = 40;
  localparam int unsigned MAX_RATE_NS     = 500;
  localparam int unsigned MIN_SAMPLE_CYC  =
    (MAX_RATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SAMPLES_PER_CM  = 100;
  localparam int unsigned LIVE_LIMIT_MS   = 500;
  localparam int unsigned LIVE_MAX_DIV    =
    LIVE_LIMIT_MS * 1000000 / CLK_PERIOD_NS / SAMPLES_PER_CM;
  localparam int unsigned AUTO_WAIT_MS    = 100;
  localparam int unsigned AUTO_WAIT_CYC   =
    AUTO_WAIT_MS * 1000000 / CLK_PERIOD_NS;
  // store geometry
  localparam int unsigned STORE_DEPTH     = 1024;
  localparam int unsigned STORE_AW        = 10;
  localparam int unsigned STORE_DW        = 8;
  localparam logic [10:0] SWEEP_LAST      = 11'(STORE_DEPTH - 1);
  localparam logic [10:0] POST_QUARTER    = 11'(STORE_DEPTH / 4 - 1);
  localparam logic [10:0] POST_HALF       = 11'(STORE_DEPTH / 2 - 1);
  // register map
  localparam logic [7:0]  OFF_CTRL        = 8'h00;
  localparam logic [7:0]  OFF_SWEEP       = 8'h04;
  localparam logic [7:0]  OFF_CMD         = 8'h08;
  localparam logic [7:0]  OFF_STATUS      = 8'h0c;
  localparam logic [7:0]  OFF_WPTR        = 8'h10;
  localparam logic [7:0]  CTRL_RST        = 8'h00;
  localparam logic [23:0] SWEEP_RST       = 24'h000064;
  localparam int unsigned CMD_STORE_BIT   = 0;
  localparam int unsigned CMD_REL_BIT     = 1;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef enum logic [1:0] {M_LIVE, M_REFR, M_ROLL} wss_mode_e;
  typedef enum logic [1:0] {TP_END, TP_TQ, TP_HALF} wss_tp_e;
  typedef enum logic [1:0] {S_OFF, S_ARMED, S_TRIGD, S_STORED} wss_seq_e;
endpackage

// ===== rtl/wss_store.sv
`timescale 1ns/1ps
module wss_store
  import wss_pkg::*;
#(
  parameter int unsigned AW = STORE_AW,
  parameter int unsigned DW = STORE_DW
) (
  input  wire logic          core_clk,
  input  wire logic          nrst,
  wss_wr_if.mem              wr,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  typedef struct packed {
    logic [DW-1:0] rdata;
  } wss_st_s;

  logic [DW-1:0] mem [0:(1<<AW)-1];
  wss_st_s       r;
  wss_st_s       next_r;

  // write replaces the old word, no erase step
  always_ff @(posedge core_clk) begin
    if (wr.we) begin
      mem[wr.waddr] <= wr.wdata;
    end
  end

  // registered display read
  always_comb begin
    next_r       = r;
    next_r.rdata = mem[raddr];
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign rdata = r.rdata;
endmodule

// ===== rtl/wss_top.sv
`timescale 1ns/1ps
module wss_top
  import wss_pkg::*;
#(
  parameter int unsigned AUTO_WAIT = AUTO_WAIT_CYC,
  parameter int unsigned LIVE_MAX  = LIVE_MAX_DIV
) (
  input  wire logic                core_clk,
  input  wire logic                nrst,
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic                trig_in,
  input  wire logic [STORE_DW-1:0] sample_in,
  input  wire logic [STORE_AW-1:0] disp_addr,
  output logic      [STORE_DW-1:0] disp_data,
  output logic                     ind_live,
  output logic                     ind_refr,
  output logic                     ind_roll,
  output logic                     lamp_armed,
  output logic                     lamp_trig,
  output logic                     lamp_stored,
  output logic                     sweep_on,
  output logic                     free_run,
  output logic      [STORE_AW-1:0] roll_origin,
  output logic      [STORE_AW-1:0] trig_mark
);
  typedef struct packed {
    logic [7:0]          aw_addr;
    logic                aw_hold;
    logic [31:0]         w_data;
    logic [3:0]          w_strb;
    logic                w_hold;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
    logic [1:0]          sel;
    logic                auto_dis;
    logic [1:0]          tpoint;
    logic [23:0]         sweep_div;
    wss_mode_e           mode;
    wss_seq_e            seq;
    logic                sweeping;
    logic                fill_ok;
    logic [10:0]         scnt;
    logic [21:0]         idle_cnt;
    logic [STORE_AW-1:0] waddr;
    logic [STORE_AW-1:0] trig_addr;
    logic [4:0]          tick_gap;
  } wss_top_s;

  wss_top_s    r;
  wss_top_s    next_r;
  wss_mode_e   eff;
  logic        tick;
  logic        wr_go;
  logic        store_cmd;
  logic        rel_cmd;
  logic        auto_go;
  logic [31:0] ctrl_word;
  logic [10:0] post_last;

  wss_wr_if #(.AW(STORE_AW), .DW(STORE_DW)) wr ();

  // byte-lane merge for register writes
  function automatic logic [31:0] lane_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  wss_pacer u_pacer (
    .core_clk (core_clk),
    .nrst     (nrst),
    .div      (r.sweep_div),
    .tick     (tick)
  );

  wss_store u_store (
    .core_clk (core_clk),
    .nrst     (nrst),
    .wr       (wr),
    .raddr    (disp_addr),
    .rdata    (disp_data)
  );

  // bus handshakes and decoded command pulses
  assign s_axi_awready = !r.aw_hold;
  assign s_axi_wready  = !r.w_hold;
  assign s_axi_arready = !r.rvalid;
  assign wr_go     = r.aw_hold && r.w_hold && !r.bvalid;
  assign store_cmd = wr_go && r.aw_addr == OFF_CMD && r.w_strb[0]
                     && r.w_data[CMD_STORE_BIT];
  assign rel_cmd   = wr_go && r.aw_addr == OFF_CMD && r.w_strb[0]
                     && r.w_data[CMD_REL_BIT];
  assign ctrl_word = {24'h0, 3'h0, r.tpoint, r.auto_dis, r.sel};

  // selected mode, non-roll forced refreshed on slow sweeps
  always_comb begin
    if (r.sel == M_ROLL) begin
      eff = M_ROLL;
    end else if (r.sel == M_REFR || r.sweep_div > 24'(LIVE_MAX)) begin
      eff = M_REFR;
    end else begin
      eff = M_LIVE;
    end
  end

  // store port: writes in refreshed sweeps and unfrozen roll
  assign wr.we = tick && ((r.mode == M_REFR && r.sweeping)
                 || (r.mode == M_ROLL && r.seq != S_STORED));
  assign wr.waddr = r.waddr;
  assign wr.wdata = sample_in;
  assign auto_go  = r.mode == M_LIVE && !r.auto_dis && !r.sweeping
                    && !trig_in && r.idle_cnt == 22'(AUTO_WAIT - 1);
  assign post_last = (r.tpoint == TP_HALF) ? POST_HALF
                                           : POST_QUARTER;

  // next-state logic for bus, registers and sequencer
  always_comb begin
    next_r = r;
    if (s_axi_awvalid && !r.aw_hold) begin
      next_r.aw_hold = 1'b1;
      next_r.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r.w_hold) begin
      next_r.w_hold = 1'b1;
      next_r.w_data = s_axi_wdata;
      next_r.w_strb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end
    if (wr_go) begin
      next_r.aw_hold = 1'b0;
      next_r.w_hold  = 1'b0;
      next_r.bvalid  = 1'b1;
      next_r.bresp   = RESP_OKAY;
      unique case (r.aw_addr)
        OFF_CTRL: begin
          {next_r.tpoint, next_r.auto_dis, next_r.sel} =
            5'(lane_merge(ctrl_word, r.w_data, r.w_strb));
        end
        OFF_SWEEP: begin
          next_r.sweep_div = 24'(lane_merge({8'h0, r.sweep_div},
                                            r.w_data, r.w_strb));
        end
        OFF_CMD, OFF_STATUS, OFF_WPTR: begin
        end
        default: next_r.bresp = RESP_SLVERR;
      endcase
    end
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !r.rvalid) begin
      next_r.rvalid = 1'b1;
      next_r.rresp  = RESP_OKAY;
      unique case (s_axi_araddr)
        OFF_CTRL:   next_r.rdata = ctrl_word;
        OFF_SWEEP:  next_r.rdata = {8'h0, r.sweep_div};
        OFF_CMD:    next_r.rdata = 32'h0;
        OFF_STATUS: next_r.rdata = {24'h0, r.fill_ok, r.sweeping,
                                    r.seq, 2'h0, r.mode};
        OFF_WPTR:   next_r.rdata = {6'h0, r.trig_addr, 6'h0, r.waddr};
        default: begin
          next_r.rdata = 32'h0;
          next_r.rresp = RESP_SLVERR;
        end
      endcase
    end

    // write pointer wraps around the store; tick spacing kept
    if (wr.we) begin
      next_r.waddr = r.waddr + STORE_AW'(1);
    end
    next_r.tick_gap = tick ? 5'h1 : r.tick_gap + 5'(r.tick_gap != 5'h1f);
    next_r.mode = eff;
    if (eff != r.mode) begin
      next_r.seq      = S_OFF;
      next_r.sweeping = 1'b0;
      next_r.scnt     = '0;
      next_r.fill_ok  = 1'b0;
      next_r.idle_cnt = '0;
    end else begin
      unique case (r.mode)
        M_LIVE: begin
          // store and release have no effect here
          if (!r.sweeping && (trig_in || auto_go)) begin
            next_r.sweeping = 1'b1;
            next_r.scnt     = '0;
            next_r.idle_cnt = '0;
          end else if (!r.sweeping
                       && r.idle_cnt != 22'(AUTO_WAIT - 1)) begin
            next_r.idle_cnt = r.idle_cnt + 22'h1;
          end
          if (r.sweeping && tick) begin
            next_r.scnt = r.scnt + 11'h1;
            if (r.scnt == SWEEP_LAST) begin
              next_r.sweeping = 1'b0;
            end
          end
        end
        M_REFR: begin
          // stored trace is redisplayed until a trigger
          if (!r.sweeping && trig_in && r.seq != S_STORED) begin
            next_r.sweeping = 1'b1;
            next_r.waddr    = '0;
            next_r.scnt     = '0;
            if (r.seq == S_ARMED) begin
              next_r.seq = S_TRIGD;
            end
          end
          if (r.seq == S_ARMED && r.sweeping) begin
            next_r.seq = S_TRIGD;
          end
          if (wr.we) begin
            next_r.scnt = r.scnt + 11'h1;
            if (r.scnt == SWEEP_LAST) begin
              next_r.sweeping = 1'b0;
              if (r.seq == S_TRIGD) begin
                next_r.seq = S_STORED;
              end
            end
          end
          if (store_cmd && (r.seq == S_OFF || r.seq == S_STORED)) begin
            next_r.seq = S_ARMED;
          end
          if (rel_cmd) begin
            next_r.seq = S_OFF;
          end
        end
        M_ROLL: begin
          // count the old contents rolling out
          if (wr.we && !r.fill_ok) begin
            next_r.scnt = r.scnt + 11'h1;
            if (r.scnt == SWEEP_LAST) begin
              next_r.fill_ok = 1'b1;
            end
          end
          if (r.seq == S_ARMED && trig_in && r.fill_ok) begin
            next_r.trig_addr = r.waddr;
            next_r.scnt      = wr.we ? 11'h1 : 11'h0;
            if (r.tpoint == TP_TQ || r.tpoint == TP_HALF) begin
              next_r.seq = S_TRIGD;
            end else begin
              next_r.seq = S_STORED;
            end
          end
          if (r.seq == S_TRIGD && wr.we) begin
            next_r.scnt = r.scnt + 11'h1;
            if (r.scnt == post_last) begin
              next_r.seq = S_STORED;
            end
          end
          if (store_cmd && (r.seq == S_OFF || r.seq == S_STORED)) begin
            next_r.seq = S_ARMED;
          end
          if ((store_cmd || rel_cmd) && r.seq == S_STORED) begin
            next_r.fill_ok = 1'b0;
            next_r.scnt    = '0;
          end
          if (rel_cmd) begin
            next_r.seq = S_OFF;
          end
        end
        default: begin
          next_r.seq = S_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      r           <= '0;
      r.sel       <= CTRL_RST[1:0];
      r.sweep_div <= SWEEP_RST;
      r.mode      <= M_LIVE;
      r.seq       <= S_OFF;
      r.tick_gap  <= '1;
    end else begin
      r <= next_r;
    end
  end

  // outputs decoded from state; free_run also gated by trig_in
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp  = r.bresp;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata  = r.rdata;
  assign s_axi_rresp  = r.rresp;
  assign ind_live     = r.mode == M_LIVE;
  assign ind_refr     = r.mode == M_REFR;
  assign ind_roll     = r.mode == M_ROLL;
  assign lamp_armed   = r.seq == S_ARMED;
  assign lamp_trig    = r.seq == S_TRIGD;
  assign lamp_stored  = r.seq == S_STORED;
  assign sweep_on     = r.sweeping || (r.mode == M_ROLL
                        && r.seq != S_STORED);
  assign free_run     = auto_go;
  assign roll_origin  = r.waddr;
  assign trig_mark    = r.trig_addr;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  live_ignore_a: assert property (
    r.mode == M_LIVE && r.seq == S_OFF |=> r.seq == S_OFF)
    else $error("store command acted in live mode");

  arm_on_store_a: assert property (
    r.mode != M_LIVE && eff == r.mode && store_cmd && r.seq == S_OFF
    && !rel_cmd |=> r.seq == S_ARMED)
    else $error("armed lamp not lit after store");

  sweep_trig_a: assert property (
    r.mode == M_REFR && eff == M_REFR && r.seq == S_ARMED
    && r.sweeping && !rel_cmd |=> lamp_trig && !lamp_armed)
    else $error("triggered lamp missing at sweep start");

  done_store_a: assert property (
    r.mode == M_REFR && eff == M_REFR && r.seq == S_TRIGD && wr.we
    && r.scnt == SWEEP_LAST && !rel_cmd |=> lamp_stored && !lamp_trig)
    else $error("stored lamp missing at sweep end");

  end_skip_a: assert property (
    r.mode == M_ROLL && eff == M_ROLL && r.seq == S_ARMED && trig_in
    && r.fill_ok && r.tpoint == TP_END && !rel_cmd
    |=> lamp_stored && !lamp_trig)
    else $error("end-point capture did not freeze at once");

  frozen_a: assert property (
    r.seq == S_STORED |-> !wr.we)
    else $error("store written while held");

  roll_write_a: assert property (
    r.mode == M_ROLL && r.seq == S_OFF && tick |-> wr.we)
    else $error("roll mode missed a sample");

  rate_cap_a: assert property (
    tick |-> r.tick_gap >= 5'(MIN_SAMPLE_CYC))
    else $error("sample rate above cap");

  auto_off_a: assert property (
    r.mode != M_LIVE || r.auto_dis |-> !free_run)
    else $error("free run outside enabled live mode");

  live_limit_a: assert property (
    r.sel == M_LIVE && r.sweep_div > 24'(LIVE_MAX) |=> r.mode != M_LIVE)
    else $error("live mode on slow sweep");
endmodule

// ===== rtl/wss_wr_if.sv
`timescale 1ns/1ps
interface wss_wr_if #(
  parameter int unsigned AW = 10,
  parameter int unsigned DW = 8
);
  logic          we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  modport src (output we, output waddr, output wdata);
  modport mem (input we, input waddr, input wdata);
endinterface

// ===== tb/waveform_store_mode_sequencer_tb.sv
`timescale 1ns/1ps
module waveform_store_mode_sequencer_tb;
  import wss_pkg::*;
  logic                core_clk, nrst, trig_in, free_run, sweep_on;
  logic [7:0]          awaddr, araddr;
  logic                awvalid, awready, wvalid, wready, bvalid;
  logic                bready, arvalid, arready, rvalid, rready;
  logic [31:0]         wdata, rdata, m;
  logic [3:0]          wstrb;
  logic [1:0]          bresp, rresp;
  logic [33:0]         e;
  logic [STORE_DW-1:0] sample_in, disp_data, lva, lvb;
  logic [STORE_AW-1:0] disp_addr, roll_origin, trig_mark, p;
  logic                ind_live, ind_refr, ind_roll;
  logic                lamp_armed, lamp_trig, lamp_stored;
  int                  err_total = 0, n_checks = 0;
  int                  fr_cnt = 0, tr_cnt = 0, seed, f;
  logic [33:0]         qr[$];
  logic [31:0]         qm[$];
  logic [1:0]          qb[$];

  wss_top #(.AUTO_WAIT(50), .LIVE_MAX(200)) DUT (
    .core_clk(core_clk), .nrst(nrst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .trig_in(trig_in),
    .sample_in(sample_in), .disp_addr(disp_addr),
    .disp_data(disp_data), .ind_live(ind_live),
    .ind_refr(ind_refr), .ind_roll(ind_roll),
    .lamp_armed(lamp_armed), .lamp_trig(lamp_trig),
    .lamp_stored(lamp_stored), .sweep_on(sweep_on),
    .free_run(free_run), .roll_origin(roll_origin),
    .trig_mark(trig_mark)
  );

  wss_panel pan (
    .core_clk(core_clk), .trig_in(trig_in), .sample_in(sample_in)
  );

  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] g);
    n_checks++;
    if (g !== ex) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, ex, g);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic tmo(input string nm);
    err_total++;
    $display("BAD %s expected done seen timeout", nm);
    conclude();
  endtask

  // write: address and data offered together, held until taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = RESP_OKAY,
                    input logic [3:0] sb = 4'hf);
    int n;
    n = 0;
    qb.push_back(er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    wstrb <= sb;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
      if (n > 200) tmo("write");
    end while (!bvalid);
    bready <= 1'b0;
    @(posedge core_clk);
  endtask

  // read: expected word and mask noted before the request
  task automatic rd(input logic [7:0] a, input logic [31:0] ex,
                    input logic [31:0] mk = 32'hffffffff,
                    input logic [1:0] er = RESP_OKAY);
    int n;
    n = 0;
    qr.push_back({er, ex});
    qm.push_back(mk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
      n++;
      if (n > 200) tmo("read");
    end while (!rvalid);
    rready <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic st(input logic [1:0] md, input logic [1:0] sq);
    rd(OFF_STATUS, 32'({sq, 2'h0, md}), 32'h00000033);
  endtask

  // random display addresses must all hold the captured level
  task automatic peek(input logic [STORE_DW-1:0] ex);
    repeat (4) begin
      disp_addr <= 10'($random(seed));
      @(posedge core_clk);
      @(posedge core_clk);
      chk("disp_data", 32'(ex), 32'(disp_data));
    end
  endtask

  task automatic wst();
    int n;
    n = 0;
    while (lamp_stored !== 1'b1) begin
      @(posedge core_clk);
      n++;
      if (n > 20000) tmo("lamp_stored");
    end
  endtask

  // count write pointer steps and their spacing
  task automatic rollw(input int k);
    int c, t;
    logic [STORE_AW-1:0] q;
    c = 0;
    t = 0;
    q = roll_origin;
    while (c < k) begin
      @(posedge core_clk);
      t++;
      if (roll_origin !== q) c++;
      q = roll_origin;
      if (t > k * 20) tmo("roll");
    end
    chk("tick", 1, 32'(t > (k - 1) * MIN_SAMPLE_CYC &&
                       t <= k * MIN_SAMPLE_CYC));
  endtask

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // watcher pairs each bus answer with the oldest note
  always @(posedge core_clk) begin
    if (free_run === 1'b1) fr_cnt++;
    if (lamp_trig === 1'b1) tr_cnt++;
    if (rvalid && rready && qr.size() > 0) begin
      e = qr.pop_front();
      m = qm.pop_front();
      chk("rresp", 32'(e[33:32]), 32'(rresp));
      chk("rdata", e[31:0], rdata & m);
    end
    if (bvalid && bready && qb.size() > 0) begin
      chk("bresp", 32'(qb.pop_front()), 32'(bresp));
    end
  end

  initial begin
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b0;
    arvalid <= 1'b0;
    rready <= 1'b0;
    awaddr <= '0;
    araddr <= '0;
    wdata <= '0;
    wstrb <= 4'h0;
    disp_addr <= '0;
    seed = 70042;
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    rd(OFF_CTRL, 32'(CTRL_RST));
    rd(OFF_SWEEP, 32'(SWEEP_RST));
    chk("ind_live", 1, 32'(ind_live));
    wr(8'h20, 32'h1, RESP_SLVERR);
    rd(8'h20, 32'h0, 32'hffffffff, RESP_SLVERR);
    rd(OFF_CMD, 32'h0);
    wr(OFF_SWEEP, 32'h00abcd05, RESP_OKAY, 4'h1);
    rd(OFF_SWEEP, 32'h5);
    $display("test reset done");
    wr(OFF_CTRL, 32'h1);
    wr(OFF_CTRL, 32'h4);
    f = fr_cnt;
    repeat (200) @(posedge core_clk);
    chk("free_run", 32'(f), 32'(fr_cnt));
    wr(OFF_CTRL, 32'h0);
    repeat (100) @(posedge core_clk);
    chk("free_run", 1, 32'(fr_cnt > f));
    wr(OFF_CMD, 32'h1);
    st(M_LIVE, S_OFF);
    wr(OFF_SWEEP, 32'd201);
    st(M_REFR, S_OFF);
    chk("ind_refr", 1, 32'(ind_refr));
    wr(OFF_SWEEP, 32'd200);
    st(M_LIVE, S_OFF);
    wr(OFF_SWEEP, 32'h5);
    $display("test live done");
    wr(OFF_CTRL, 32'h1);
    f = fr_cnt;
    repeat (100) @(posedge core_clk);
    chk("sweep_on", 0, 32'(sweep_on));
    lva = 8'($random(seed));
    lvb = ~lva;
    pan.level = lva;
    wr(OFF_CMD, 32'h1);
    st(M_REFR, S_ARMED);
    chk("lamp_armed", 1, 32'(lamp_armed));
    pan.fire(0);
    st(M_REFR, S_TRIGD);
    chk("sweep_on", 1, 32'(sweep_on));
    wst();
    st(M_REFR, S_STORED);
    chk("lamp_trig", 0, 32'(lamp_trig));
    peek(lva);
    pan.level = lvb;
    pan.fire(3);
    repeat (20) @(posedge core_clk);
    chk("sweep_on", 0, 32'(sweep_on));
    peek(lva);
    wr(OFF_CMD, 32'h1);
    st(M_REFR, S_ARMED);
    pan.fire(0);
    wst();
    peek(lvb);
    chk("free_run", 32'(f), 32'(fr_cnt));
    wr(OFF_CMD, 32'h2);
    st(M_REFR, S_OFF);
    pan.fire(0);
    repeat (3) @(posedge core_clk);
    chk("sweep_on", 1, 32'(sweep_on));
    wr(OFF_CMD, 32'h1);
    st(M_REFR, S_TRIGD);
    $display("test refreshed done");
    wr(OFF_CTRL, 32'h2);
    chk("ind_roll", 1, 32'(ind_roll));
    rollw(1030);
    chk("sweep_on", 1, 32'(sweep_on));
    wr(OFF_CMD, 32'h1);
    st(M_ROLL, S_ARMED);
    f = tr_cnt;
    pan.fire(1);
    repeat (2) @(posedge core_clk);
    st(M_ROLL, S_STORED);
    chk("lamp_trig", 32'(f), 32'(tr_cnt));
    p = roll_origin;
    repeat (40) @(posedge core_clk);
    chk("roll_origin", 32'(p), 32'(roll_origin));
    wr(OFF_CTRL, 32'h0a);
    wr(OFF_CMD, 32'h1);
    pan.fire(0);
    repeat (5) @(posedge core_clk);
    st(M_ROLL, S_ARMED);
    rollw(1030);
    pan.fire(0);
    st(M_ROLL, S_TRIGD);
    wst();
    chk("post", 32'd256, 32'(10'(roll_origin - trig_mark)));
    wr(OFF_CMD, 32'h2);
    st(M_ROLL, S_OFF);
    chk("sweep_on", 1, 32'(sweep_on));
    wr(OFF_CTRL, 32'h12);
    wr(OFF_CMD, 32'h1);
    rollw(1030);
    pan.fire(0);
    wst();
    chk("post", 32'd512, 32'(10'(roll_origin - trig_mark)));
    $display("test roll done");
    conclude();
  end
endmodule

// ===== tb/wss_panel.sv
`timescale 1ns/1ps
// trigger detector and converter stand-in
module wss_panel
  import wss_pkg::*;
(
  input  wire logic                core_clk,
  output logic                     trig_in,
  output logic      [STORE_DW-1:0] sample_in
);
  logic [STORE_DW-1:0] level;

  initial begin
    trig_in = 1'b0;
    sample_in = '0;
    level = '0;
  end

  // converter presents the held level at every edge
  always @(posedge core_clk) begin
    sample_in <= level;
  end

  // one-cycle trigger pulse, prompt or after a delay
  task automatic fire(input int dly);
    repeat (dly) @(posedge core_clk);
    @(posedge core_clk);
    trig_in <= 1'b1;
    @(posedge core_clk);
    trig_in <= 1'b0;
  endtask
endmodule
